// ===== spc_pkg.sv
package spc_pkg;
   localparam logic [7:0] SPC_CMD_DESEL = 8'h02;
   localparam logic [7:0] SPC_CMD_CH_EN = 8'h03;
   localparam logic [7:0] SPC_CMD_CH_DIS = 8'h04;
   localparam logic [7:0] SPC_CMD_CH_RST = 8'h05;
   localparam logic [7:0] SPC_RSP_FLAG = 8'h80;
   localparam logic [4:0] SPC_PKG_CHAN = 5'h1F;
   localparam logic [15:0] SPC_RSP_OK = 16'h0000;
   localparam logic [15:0] SPC_REASON_NONE = 16'h0000;
   localparam int SPC_CLK_HZ = 25000000;
   localparam int SPC_FLOAT_NS = 2000;
   localparam int SPC_FLOAT_CYC_RAW = (SPC_FLOAT_NS * (SPC_CLK_HZ / 1000000)) / 1000;
   localparam int SPC_FLOAT_CYC = (SPC_FLOAT_CYC_RAW < 1) ? 1 : SPC_FLOAT_CYC_RAW;
   localparam int SPC_MAX_CHAN = 4;

   typedef struct packed {
      logic [7:0] code;
      logic [7:0] iid;
      logic [2:0] pkg_id;
      logic [4:0] chan_id;
      logic permit_link_drop;
   } spc_cmd_t;

   typedef struct packed {
      logic [7:0] code;
      logic [7:0] iid;
      logic [2:0] pkg_id;
      logic [4:0] chan_id;
      logic [15:0] rsp_code;
      logic [15:0] reason;
   } spc_rsp_t;

   typedef enum logic [1:0] {
      SPC_ST_IDLE = 2'b00,
      SPC_ST_RESP = 2'b01,
      SPC_ST_FLOAT = 2'b11
   } spc_state_t;
endpackage

// ===== spc_float_timer.sv
`timescale 1ns/100ps
`default_nettype none
module spc_float_timer
   import spc_pkg::*;
#(
   parameter int CYCLES = SPC_FLOAT_CYC
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic start_i,
   output logic busy_o,
   output logic done_o
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);
   logic [CW-1:0] cnt_reg;
   logic busy_reg;
   logic done_reg;

   // Down counter; done pulses for one cycle as busy falls, CYCLES cycles after start
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_reg <= '0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         if (start_i) begin
            cnt_reg <= LOAD;
            busy_reg <= 1'b1;
         end else if (busy_reg) begin
            if (cnt_reg == '0) begin
               busy_reg <= 1'b0;
               done_reg <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg - 1'b1;
            end
         end
      end
   end
   assign busy_o = busy_reg;
   assign done_o = done_reg;
endmodule // spc_float_timer
`default_nettype wire

// ===== spc_chan_ctrl.sv
// Operation
// - Deselect stops transmit and floats outputs
// - Deselect targets package, channel field 0x1F
// - Deselected only after response and float
// - Float outputs within deselect-to-float interval
// - Shared buffers: one deselect blocks all channels
// - Deselect response always leads to deselected; a deselect to channel 0-3 is answered 0x82 and the package stays selected
// - Deselect command: header, checksum, padding
// - Response: header, codes, checksum, padding
// - Enable lets pass-through and events flow
// - Enable command: header, checksum, padding
// - Enable response code 0x83
// - Disable stops pass-through and event flow
// - Queued packets may still drain after disable
// - Disable carries permit_link_drop flag bit
// - Disable response code 0x84
// - Reset returns channel to Initial State
// - Reset command: header, reserved, checksum, padding
// - Reset response code 0x85
// - Any other addressed command reselects package
// - Selected stays so until deselect or reset-all; here only deselect and arst_n_i clear it, not all_initial_i or a package reset
`timescale 1ns/100ps
`default_nettype none
module spc_chan_ctrl
   import spc_pkg::*;
#(
   parameter int NCHAN = SPC_MAX_CHAN,
   parameter int FLOAT_CYC = SPC_FLOAT_CYC,
   parameter logic [2:0] PKG_ID = 3'h0
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic cmd_valid_i,
   input wire spc_cmd_t cmd_i,
   output logic cmd_ready_o,
   output logic rsp_valid_o,
   output spc_rsp_t rsp_o,
   input wire logic rsp_ready_i,
   input wire logic rsp_sent_i,
   input wire logic all_initial_i,
   input wire logic [NCHAN-1:0] queue_busy_i,
   output logic selected_o,
   output logic buf_oe_o,
   output logic [NCHAN-1:0] chan_en_o,
   output logic [NCHAN-1:0] flow_gate_o,
   output logic [NCHAN-1:0] permit_link_drop_o,
   output logic [NCHAN-1:0] chan_reset_o,
   output logic [NCHAN-1:0] initial_state_o
);
   spc_state_t state_reg, state_next;
   spc_rsp_t rsp_reg, rsp_next;
   logic rsp_valid_reg, rsp_valid_next;
   logic sel_reg, sel_next;
   logic oe_reg, oe_next;
   logic [NCHAN-1:0] en_reg, en_next;
   logic [NCHAN-1:0] ald_reg, ald_next;
   logic [NCHAN-1:0] init_reg, init_next;
   logic [NCHAN-1:0] rst_reg, rst_next;
   logic [NCHAN-1:0] gate_reg;
   logic ready_reg;
   logic timer_start, timer_busy, timer_done;
   logic is_desel_pending, is_rst_pending;
   logic [NCHAN-1:0] rst_mask;

   // Channel index decode, used for every channel-addressed command
   function automatic logic [NCHAN-1:0] chan_onehot(input logic [4:0] ch);
      logic [NCHAN-1:0] v;
      v = '0;
      for (int i = 0; i < NCHAN; i++) begin
         if (ch == 5'(i)) begin
            v[i] = 1'b1;
         end
      end
      return v;
   endfunction

   // Decode of the incoming command
   wire logic take = cmd_valid_i && cmd_ready_o;
   wire logic for_pkg = (cmd_i.pkg_id == PKG_ID);
   wire logic is_pkg_cmd = (cmd_i.chan_id == SPC_PKG_CHAN);
   wire logic [NCHAN-1:0] ch_hot = chan_onehot(cmd_i.chan_id);
   wire logic ch_ok = is_pkg_cmd || (ch_hot != '0);
   wire logic accept = take && for_pkg && ch_ok;
   // Framer has already checked header and checksum; only the fields we act on arrive
   wire logic is_desel = (cmd_i.code == SPC_CMD_DESEL) && is_pkg_cmd;
   wire logic is_en = (cmd_i.code == SPC_CMD_CH_EN);
   wire logic is_dis = (cmd_i.code == SPC_CMD_CH_DIS);
   wire logic is_rst = (cmd_i.code == SPC_CMD_CH_RST);
   wire logic rsp_done = rsp_valid_reg && rsp_ready_i;

   // Command ready only while idle so one response pairs with one command;
   // registered from the next-state values so it keeps the same timing
   wire logic ready_next = (state_next == SPC_ST_IDLE) && !rsp_valid_next;
   assign cmd_ready_o = ready_reg;

   // Response builder and sequencing
   always_comb begin
      state_next = state_reg;
      rsp_next = rsp_reg;
      rsp_valid_next = rsp_valid_reg;
      sel_next = sel_reg;
      oe_next = oe_reg;
      en_next = en_reg;
      ald_next = ald_reg;
      init_next = init_reg;
      rst_next = '0;
      timer_start = 1'b0;
      if (all_initial_i) begin
         init_next = '1;
      end
      case (state_reg)
         SPC_ST_IDLE: begin
            if (accept) begin
               rsp_next.code = cmd_i.code | SPC_RSP_FLAG;
               rsp_next.iid = cmd_i.iid;
               rsp_next.pkg_id = cmd_i.pkg_id;
               rsp_next.chan_id = cmd_i.chan_id;
               rsp_next.rsp_code = SPC_RSP_OK;
               rsp_next.reason = SPC_REASON_NONE;
               rsp_valid_next = 1'b1;
               oe_next = 1'b1;
               state_next = SPC_ST_RESP;
               if (!is_desel) begin
                  sel_next = 1'b1;
               end
               if (is_en) begin
                  en_next = en_reg | ch_hot;
               end
               if (is_dis) begin
                  en_next = en_reg & ~ch_hot;
                  ald_next = (ald_reg & ~ch_hot) | ({NCHAN{cmd_i.permit_link_drop}} & ch_hot);
               end
            end
         end
         SPC_ST_RESP: begin
            if (rsp_done) begin
               rsp_valid_next = 1'b0;
            end
            if (rsp_sent_i || (rsp_done && !is_desel_pending)) begin
               state_next = SPC_ST_IDLE;
               if (is_desel_pending) begin
                  oe_next = 1'b0;
                  timer_start = 1'b1;
                  state_next = SPC_ST_FLOAT;
               end
               if (is_rst_pending) begin
                  rst_next = rst_mask;
                  init_next = init_reg | rst_mask;
                  en_next = en_reg & ~rst_mask;
                  ald_next = ald_reg & ~rst_mask;
               end
            end
         end
         SPC_ST_FLOAT: begin
            if (timer_done) begin
               sel_next = 1'b0;
               state_next = SPC_ST_IDLE;
            end
         end
         default: begin
            state_next = SPC_ST_IDLE;
         end
      endcase
   end

   // Pending command kind, held while the response is out
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         is_desel_pending <= 1'b0;
         is_rst_pending <= 1'b0;
         rst_mask <= '0;
      end else if (accept) begin
         is_desel_pending <= is_desel;
         is_rst_pending <= is_rst;
         rst_mask <= is_pkg_cmd ? '1 : ch_hot;
      end
   end

   // Any accepted channel command clears Initial State of its channel; package commands clear none
   wire logic [NCHAN-1:0] clr_init = accept ? (is_pkg_cmd ? '0 : ch_hot) : '0;

   // Main state registers
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg <= SPC_ST_IDLE;
         rsp_reg <= '0;
         rsp_valid_reg <= 1'b0;
         sel_reg <= 1'b0;
         oe_reg <= 1'b0;
         en_reg <= '0;
         ald_reg <= '0;
         init_reg <= '1;
         rst_reg <= '0;
         ready_reg <= 1'b1;
      end else begin
         ready_reg <= ready_next;
         state_reg <= state_next;
         rsp_reg <= rsp_next;
         rsp_valid_reg <= rsp_valid_next;
         sel_reg <= sel_next;
         oe_reg <= oe_next;
         en_reg <= en_next;
         ald_reg <= ald_next;
         init_reg <= init_next & ~(clr_init & ~rst_next); // clear wins, except over a reset pulse
         rst_reg <= rst_next;
      end
   end

   // Flow gate: enabled channels send; shared buffers block all when deselected.
   // Queued packets of a disabled channel may drain; reset keeps sending until response.
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         gate_reg <= '0;
      end else begin
         // A draining channel keeps its gate only while its queue holds packets
         gate_reg <= ({NCHAN{sel_next && oe_next}}) &
            (en_next | (gate_reg & queue_busy_i & ~rst_next));
      end
   end

   spc_float_timer #(
      .CYCLES(FLOAT_CYC)
   ) u_timer (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .start_i(timer_start),
      .busy_o(timer_busy),
      .done_o(timer_done)
   );

   assign rsp_valid_o = rsp_valid_reg;
   assign rsp_o = rsp_reg;
   assign selected_o = sel_reg;
   assign buf_oe_o = oe_reg;
   assign chan_en_o = en_reg;
   assign flow_gate_o = gate_reg;
   assign permit_link_drop_o = ald_reg;
   assign chan_reset_o = rst_reg;
   assign initial_state_o = init_reg;

   // Checks on the command sequencing
   a_float_after_resp: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (state_reg == SPC_ST_RESP && is_desel_pending && rsp_sent_i) |=> !oe_reg)
      else $error("outputs not floated after deselect response");
   a_desel_needs_float: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      $fell(sel_reg) |-> !oe_reg && $past(state_reg) == SPC_ST_FLOAT)
      else $error("deselected without float");
   a_desel_timing: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      $rose(timer_busy) |-> ##[1:1000] !sel_reg)
      else $error("deselect never completed");
   a_no_send_float: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      !oe_reg |-> flow_gate_o == '0)
      else $error("traffic while floated");
   a_resp_code: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      accept |=> rsp_valid_o && rsp_o.code == ($past(cmd_i.code) | SPC_RSP_FLAG))
      else $error("wrong response code");
   a_resp_iid: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      accept |=> rsp_o.iid == $past(cmd_i.iid))
      else $error("instance id not echoed");
   a_reselect: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (accept && !is_desel) |=> selected_o)
      else $error("package not reselected");
   a_enable_sets: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (accept && is_en) |=> (chan_en_o & $past(ch_hot)) == $past(ch_hot))
      else $error("channel not enabled");
   a_disable_clears: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (accept && is_dis) |=> (chan_en_o & $past(ch_hot)) == '0)
      else $error("channel not disabled");
   a_reset_initial: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (chan_reset_o != '0) |-> (initial_state_o & chan_reset_o) == chan_reset_o)
      else $error("reset left channel outside initial state");

   c_deselect: cover property (@(posedge clk_i) disable iff (!arst_n_i) $fell(sel_reg));
   c_enable: cover property (@(posedge clk_i) disable iff (!arst_n_i) accept && is_en);
   c_disable_ald: cover property (@(posedge clk_i) disable iff (!arst_n_i)
      accept && is_dis && cmd_i.permit_link_drop);
   c_reset: cover property (@(posedge clk_i) disable iff (!arst_n_i) chan_reset_o != '0);
endmodule // spc_chan_ctrl
`default_nettype wire

// ===== spc_mc_model.sv
`timescale 1ns/100ps
`default_nettype none
module spc_mc_model
   import spc_pkg::*;
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic rsp_valid_i,
   input wire logic [3:0] delay_i,
   output logic rsp_ready_o,
   output logic rsp_sent_o
);
   logic [3:0] wait_reg;
   logic [3:0] send_reg;
   logic busy_reg;
   // Take each answer whole after a chosen wait, then report it sent
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wait_reg <= 4'h0;
         send_reg <= 4'h0;
         busy_reg <= 1'b0;
         rsp_ready_o <= 1'b0;
         rsp_sent_o <= 1'b0;
      end else begin
         rsp_ready_o <= 1'b0;
         rsp_sent_o <= 1'b0;
         if (rsp_valid_i && !rsp_ready_o && !busy_reg) begin
            wait_reg <= wait_reg + 4'h1;
            if (wait_reg >= delay_i) begin
               rsp_ready_o <= 1'b1;
               wait_reg <= 4'h0;
               busy_reg <= 1'b1;
            end
         end
         // Serialising the frame takes a few cycles on the wire
         if (busy_reg) begin
            send_reg <= send_reg + 4'h1;
            if (send_reg == 4'h3) begin
               rsp_sent_o <= 1'b1;
               busy_reg <= 1'b0;
               send_reg <= 4'h0;
            end
         end
      end
   end
endmodule // spc_mc_model
`default_nettype wire

// ===== spc_chan_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("Error %s exp %0h got %0h", n, e, g); end end
module spc_chan_ctrl_tb_top;
   import spc_pkg::*;
   localparam int FC = 3;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic cmd_valid = 1'b0;
   spc_cmd_t cmd = '0;
   spc_rsp_t rsp;
   spc_rsp_t r;
   logic cmd_ready, rsp_valid, rsp_ready, rsp_sent, sel, oe;
   logic [3:0] q_busy = 4'h0;
   logic [3:0] dly = 4'h0;
   logic all_init = 1'b0;
   int n_rst = 0;
   logic [3:0] en, gate, pld, crst, init;
   int n_mismatch = 0;
   int n_checks = 0;
   always #20 clk_i = ~clk_i;
   spc_chan_ctrl #(.NCHAN(4), .FLOAT_CYC(FC), .PKG_ID(3'h0)) uut (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .cmd_valid_i(cmd_valid), .cmd_i(cmd),
      .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid), .rsp_o(rsp),
      .rsp_ready_i(rsp_ready), .rsp_sent_i(rsp_sent), .all_initial_i(all_init),
      .queue_busy_i(q_busy), .selected_o(sel), .buf_oe_o(oe), .chan_en_o(en),
      .flow_gate_o(gate), .permit_link_drop_o(pld), .chan_reset_o(crst),
      .initial_state_o(init));
   spc_mc_model mc (.clk_i(clk_i), .arst_n_i(arst_n_i), .rsp_valid_i(rsp_valid),
      .delay_i(dly), .rsp_ready_o(rsp_ready), .rsp_sent_o(rsp_sent));
   // Count reset pulses aimed at channel 2 alone, sampled mid-cycle
   always @(negedge clk_i) if (crst === 4'h4) n_rst++;
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Offer a command, hold it until taken, then judge the answer
   task automatic send(input logic [7:0] c, input logic [4:0] ch, input logic p,
         input logic [2:0] pk, input logic [7:0] e);
      int i;
      @(posedge clk_i);
      cmd <= '{c, c ^ 8'h5A, pk, ch, p};
      cmd_valid <= 1'b1;
      i = 0;
      do @(negedge clk_i); while (cmd_ready !== 1'b1 && i++ < 99);
      @(posedge clk_i);
      cmd_valid <= 1'b0;
      i = 0;
      do @(negedge clk_i); while (!(rsp_valid === 1'b1 && rsp_ready === 1'b1) && i++ < 99);
      r = rsp;
      @(posedge clk_i);
      `CHK("code", e, r.code)
      `CHK("iid", c ^ 8'h5A, r.iid)
      `CHK("chan", ch, r.chan_id)
      `CHK("rsp_code", SPC_RSP_OK, r.rsp_code)
      `CHK("reason", SPC_REASON_NONE, r.reason)
   endtask
   // Idle again, with room for the frame to leave
   task automatic idle;
      int i;
      i = 0;
      do @(negedge clk_i); while (cmd_ready !== 1'b1 && i++ < 99);
      repeat (6) @(negedge clk_i);
   endtask
   task automatic t_enable;
      dly <= 4'h5;
      send(SPC_CMD_CH_EN, 5'h01, 1'b0, 3'h0, 8'h83);
      idle;
      `CHK("en1", 1'b1, en[1])
      `CHK("gate1", 1'b1, gate[1])
      `CHK("init1", 1'b0, init[1])
      `CHK("sel", 1'b1, sel)
      $display("enable done");
   endtask
   task automatic t_disable;
      dly <= 4'h0;
      q_busy <= 4'h2;
      send(SPC_CMD_CH_DIS, 5'h01, 1'b1, 3'h0, 8'h84);
      idle;
      `CHK("en1", 1'b0, en[1])
      `CHK("pld1", 1'b1, pld[1])
      `CHK("drain", 1'b1, gate[1])
      q_busy <= 4'h0;
      repeat (3) @(posedge clk_i);
      `CHK("gate1", 1'b0, gate[1])
      $display("disable done");
   endtask
   task automatic t_reset;
      send(SPC_CMD_CH_EN, 5'h02, 1'b0, 3'h0, 8'h83);
      idle;
      send(SPC_CMD_CH_RST, 5'h02, 1'b0, 3'h0, 8'h85);
      idle;
      `CHK("init2", 1'b1, init[2])
      `CHK("en2", 1'b0, en[2])
      `CHK("rst_pulses", 1, n_rst)
      `CHK("sel", 1'b1, sel)
      $display("reset done");
   endtask
   // Deselect: answer first, then float within the interval
   task automatic t_desel;
      int i;
      send(SPC_CMD_CH_EN, 5'h03, 1'b0, 3'h0, 8'h83);
      idle;
      dly <= 4'h2;
      send(SPC_CMD_DESEL, 5'h01, 1'b0, 3'h0, 8'h82);
      idle;
      `CHK("sel_generic", 1'b1, sel)
      send(SPC_CMD_DESEL, SPC_PKG_CHAN, 1'b0, 3'h0, 8'h82);
      `CHK("sel_at_rsp", 1'b1, sel)
      i = 0;
      do @(negedge clk_i); while (rsp_sent !== 1'b1 && i++ < 20);
      i = 0;
      do @(negedge clk_i); while (oe !== 1'b0 && i++ < 20);
      `CHK("float_in_time", 1'b1, i < FC)
      idle;
      `CHK("sel", 1'b0, sel)
      `CHK("oe", 1'b0, oe)
      `CHK("gate", 4'h0, gate)
      // Reselect only after the float interval has run out
      send(SPC_CMD_CH_EN, 5'h00, 1'b0, 3'h0, 8'h83);
      idle;
      `CHK("reselect", 1'b1, sel)
      $display("deselect done");
   endtask
   // A command for another package is dropped unanswered
   task automatic t_other_pkg;
      int i;
      @(posedge clk_i);
      cmd <= '{SPC_CMD_DESEL, 8'h11, 3'h5, SPC_PKG_CHAN, 1'b0};
      cmd_valid <= 1'b1;
      @(posedge clk_i);
      cmd_valid <= 1'b0;
      for (i = 0; i < 10; i++) begin
         @(posedge clk_i);
         `CHK("no_rsp", 1'b0, rsp_valid)
      end
      `CHK("sel", 1'b1, sel)
      // Internal condition forces every channel back to Initial State
      @(posedge clk_i);
      all_init <= 1'b1;
      @(posedge clk_i);
      all_init <= 1'b0;
      @(negedge clk_i);
      `CHK("init_all", 4'hF, init)
      $display("other package done");
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      arst_n_i <= 1'b1;
      @(posedge clk_i);
      `CHK("sel_rst", 1'b0, sel)
      `CHK("init_rst", 4'hF, init)
      `CHK("ready_rst", 1'b1, cmd_ready)
      t_enable;
      t_disable;
      t_reset;
      t_desel;
      t_other_pkg;
      give_verdict;
   end
   // Whole run is about 120 cycles; this cuts a hang short
   initial begin
      #200000;
      n_mismatch++;
      give_verdict;
   end
endmodule // spc_chan_ctrl_tb_top
`default_nettype wire
